// ==== sar_cfg.svh ====
/*
 Constants of the successive-approximation converter control:
 register offsets, field positions, reset values and timing counts.
 Assumes inclusion by bare name from the package and the design file.
*/
`ifndef SAR_CFG_SVH
`define SAR_CFG_SVH

`define OFF_CONTROL_0      4'h0
`define OFF_CONTROL_1      4'h1
`define OFF_RESULT_HIGH    4'h2
`define OFF_RESULT_LOW     4'h3
`define OFF_PIN_SELECT     4'h4
`define OFF_IRQ_ENABLE     4'h5
`define OFF_IRQ_FLAGS      4'h6

`define CTL0_FORMAT_BIT    7
`define CTL0_REF_BIT       6
`define CTL0_CHAN_HI       4
`define CTL0_CHAN_LO       2
`define CTL0_GO_BIT        1
`define CTL0_ON_BIT        0
`define CTL1_CLK_HI        6
`define CTL1_CLK_LO        4
`define IRQ_DONE_BIT       6

`define PIN_SELECT_RESET   8'hFF
`define BYTE_ZERO          8'h00
`define CTL1_MASK          8'h70
`define CTL0_MASK          8'hDF

`define RESULT_BITS        10
`define BIT_PERIODS        4'hB
`define ABORT_PERIODS      4'h2
`define OSC_TICK_CYCLES    7'h50
`define BIT_MSB            4'h9

`endif

// ==== sar_pkg.sv ====
/*
 Types shared by the converter control.
 Assumes sar_cfg.svh sits in the include path.
*/
`default_nettype none
package sar_pkg;
	`include "sar_cfg.svh"

	typedef struct packed {
		logic       channel_valid;
		logic [2:0] channel_select;
		logic       reference_select;
		logic       sample_hold;
		logic       compare_valid;
		logic [9:0] trial_code;
	} analog_ctl_t;

	typedef enum logic [1:0] {
		ST_IDLE   = 2'b00,
		ST_SAMPLE = 2'b01,
		ST_CONV   = 2'b10,
		ST_HOLD   = 2'b11
	} conv_state_t;
endpackage
`default_nettype wire

// ==== sar_adc_conversion_control.sv ====
/*
 Digital control of a 10-bit successive-approximation converter:
 Wishbone register slave, clock divider, bit sequencer, done interrupt.
 Assumes an analog front end that returns one comparator level per trial
 code, asynchronous to mclk, and a single 20 MHz system clock.
*/
// Added by the designer: the register offsets and the Wishbone slave port.
`timescale 1ns/1ps
`default_nettype none
`include "sar_cfg.svh"

// Functional notes
// - Each conversion yields a 10-bit result placed in result high/low registers.
// - Channel select field routes exactly one input to the sample-and-hold.
// - Reference select picks supply or external pin; negative reference is ground.
// - Conversion done raises an interrupt able to wake the sleeping core.
// - Clock select decodes dividers 2..64 and x11 selects the internal oscillator.
// - One conversion spans 11 bit periods: a sampling period, then one bit resolved per period.
// - Divided conversion clocks follow the system clock frequency.
// - Writing one to start/done while enabled starts a conversion.
// - On completion start/done clears, done flag sets, result pair loads.
// - Done flag is only set by hardware; software clears it.
// - Abort by clearing start/done keeps old result and holds two bit periods.
module sar_adc_conversion_control (
	input  wire logic                mclk,
	input  wire logic                rst_n,
	input  wire logic                wb_cyc_i,
	input  wire logic                wb_stb_i,
	input  wire logic                wb_we_i,
	input  wire logic [3:0]          wb_adr_i,
	input  wire logic                wb_sel_i,
	input  wire logic [7:0]          wb_dat_i,
	output logic      [7:0]          wb_dat_o,
	output logic                     wb_ack_o,
	output logic                     wb_err_o,
	input  wire logic                compare_in,
	output sar_pkg::analog_ctl_t     analog_ctl,
	output logic      [7:0]          analog_pin_select,
	output logic                     irq,
	output logic                     wake
);
	import sar_pkg::*;

	logic [7:0]  control_0_reg;
	logic [7:0]  control_1_reg;
	logic [7:0]  analog_pin_select_reg;
	logic [7:0]  irq_enable_reg;
	logic        done_flag_reg;
	logic [9:0]  result_reg;
	logic [9:0]  trial_reg;
	logic [3:0]  period_cnt_reg;
	logic [6:0]  div_cnt_reg;
	logic [6:0]  osc_cnt_reg;
	logic        cmp_meta_reg;
	logic        cmp_sync_reg;
	logic        ack_reg;
	logic [7:0]  rd_data_reg;
	conv_state_t state_reg;
	conv_state_t state_next;

	logic        bus_req;
	logic        wr_ctl0;
	logic        wr_flags;
	logic        wr_ok;
	logic        wr_ctl1;
	logic        wr_pin;
	logic        wr_irq_en;
	logic        busy;
	logic        keep_go;
	logic        addr_ok;
	logic        bit_tick;
	logic        done_evt;
	logic        abort_evt;
	logic        start_evt;
	logic [2:0]  clk_sel;
	logic [6:0]  div_last;
	logic [7:0]  rd_mux;

	// Divider terminal count for each clock select code
	function automatic logic [6:0] div_terminal(input logic [2:0] sel);
		unique case (sel)
			3'h0: div_terminal = 7'h01;
			3'h4: div_terminal = 7'h03;
			3'h1: div_terminal = 7'h07;
			3'h5: div_terminal = 7'h0F;
			3'h2: div_terminal = 7'h1F;
			3'h6: div_terminal = 7'h3F;
			default: div_terminal = 7'h00;
		endcase
	endfunction

	// Register write decode, shared by every writable register
	function automatic logic reg_hit(input logic ok, input logic [3:0] adr,
		input logic [3:0] off);
		reg_hit = ok & (adr == off);
	endfunction

	function automatic logic [7:0] result_byte(input logic [9:0] res, input logic fmt,
		input logic high);
		if (fmt) begin
			result_byte = high ? {6'h00, res[9:8]} : res[7:0];
		end else begin
			result_byte = high ? res[9:2] : {res[1:0], 6'h00};
		end
	endfunction

	assign bus_req   = wb_cyc_i & wb_stb_i & ~ack_reg;
	assign addr_ok   = wb_adr_i <= `OFF_IRQ_FLAGS;
	assign wr_ok     = bus_req & wb_we_i & wb_sel_i;
	assign wr_ctl0   = reg_hit(wr_ok, wb_adr_i, `OFF_CONTROL_0);
	assign wr_ctl1   = reg_hit(wr_ok, wb_adr_i, `OFF_CONTROL_1);
	assign wr_pin    = reg_hit(wr_ok, wb_adr_i, `OFF_PIN_SELECT);
	assign wr_irq_en = reg_hit(wr_ok, wb_adr_i, `OFF_IRQ_ENABLE);
	assign wr_flags  = reg_hit(wr_ok, wb_adr_i, `OFF_IRQ_FLAGS);
	assign busy      = (state_reg == ST_SAMPLE) | (state_reg == ST_CONV);
	assign clk_sel   = control_1_reg[`CTL1_CLK_HI:`CTL1_CLK_LO];
	assign div_last  = div_terminal(clk_sel);

	// Writing one to go while enabled and idle; same write may not also enable
	assign start_evt = wr_ctl0 & wb_dat_i[`CTL0_GO_BIT] & control_0_reg[`CTL0_ON_BIT] &
		wb_dat_i[`CTL0_ON_BIT] & (state_reg == ST_IDLE);
	assign abort_evt = wr_ctl0 & ~wb_dat_i[`CTL0_GO_BIT] & busy;
	// Go written again mid-conversion keeps running; a completion still clears it
	assign keep_go   = start_evt | (busy & wb_dat_i[`CTL0_GO_BIT] & ~done_evt);
	// Sampling tick plus ten trial ticks: the tenth trial tick ends period eleven
	assign done_evt  = (state_reg == ST_CONV) & bit_tick &
		(period_cnt_reg == `BIT_PERIODS - 4'h1) & ~abort_evt;

	// Bit period tick: divided mclk or the internal oscillator
	always_comb begin
		if (clk_sel[1:0] == 2'b11) begin
			bit_tick = osc_cnt_reg == `OSC_TICK_CYCLES;
		end else begin
			bit_tick = div_cnt_reg == div_last;
		end
	end

	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			div_cnt_reg <= 7'h00;
		end else if (state_reg == ST_IDLE || abort_evt || div_cnt_reg >= div_last) begin
			div_cnt_reg <= 7'h00;
		end else begin
			div_cnt_reg <= div_cnt_reg + 7'h01;
		end
	end

	// Oscillator stand-in: count held at zero while idle and on abort, independent of divider choice
	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			osc_cnt_reg <= 7'h00;
		end else if (state_reg == ST_IDLE || abort_evt || osc_cnt_reg == `OSC_TICK_CYCLES) begin
			osc_cnt_reg <= 7'h00;
		end else begin
			osc_cnt_reg <= osc_cnt_reg + 7'h01;
		end
	end

	// Comparator level comes from the analog domain
	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			cmp_meta_reg <= 1'b0;
			cmp_sync_reg <= 1'b0;
		end else begin
			cmp_meta_reg <= compare_in;
			cmp_sync_reg <= cmp_meta_reg;
		end
	end

	always_comb begin
		state_next = state_reg;
		unique case (state_reg)
			ST_IDLE: begin
				if (start_evt) state_next = ST_SAMPLE;
			end
			ST_SAMPLE: begin
				if (abort_evt) state_next = ST_HOLD;
				else if (bit_tick) state_next = ST_CONV;
			end
			ST_CONV: begin
				if (abort_evt) state_next = ST_HOLD;
				else if (done_evt) state_next = ST_IDLE;
			end
			ST_HOLD: begin
				// Counters restart on abort, so the hold is two whole periods
				if (bit_tick && period_cnt_reg == `ABORT_PERIODS - 4'h1) begin
					state_next = ST_IDLE;
				end
			end
		endcase
	end

	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			state_reg <= ST_IDLE;
		end else if (!control_0_reg[`CTL0_ON_BIT] && state_reg != ST_IDLE) begin
			state_reg <= ST_IDLE;
		end else begin
			state_reg <= state_next;
		end
	end

	// Period counter: first tick is the sampling period, then ten bit trials
	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			period_cnt_reg <= 4'h0;
		end else if (start_evt || abort_evt) begin
			period_cnt_reg <= 4'h0;
		end else if (state_reg != ST_IDLE && bit_tick) begin
			period_cnt_reg <= period_cnt_reg + 4'h1;
		end
	end

	// MSB first trial; keep bit on comparator high, set next lower bit
	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			trial_reg <= 10'h000;
		end else if (start_evt) begin
			trial_reg <= 10'h200;
		end else if (state_reg == ST_CONV && bit_tick && period_cnt_reg != `BIT_PERIODS) begin
			for (int i = 0; i < `RESULT_BITS; i++) begin
				if (4'(i) == `BIT_MSB - (period_cnt_reg - 4'h1)) begin
					trial_reg[i] <= cmp_sync_reg;
					if (i > 0) begin
						trial_reg[i - 1] <= 1'b1;
					end
				end
			end
		end
	end

	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			result_reg <= 10'h000;
		end else if (done_evt) begin
			// Bit 0 is decided on the completing tick itself
			result_reg <= {trial_reg[9:1], cmp_sync_reg};
		end
	end

	// Control 0: go bit cleared by hardware on done, during the abort hold, while disabled, or by reset
	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			control_0_reg <= `BYTE_ZERO;
		end else if (wr_ctl0) begin
			control_0_reg <= wb_dat_i & `CTL0_MASK;
			control_0_reg[`CTL0_GO_BIT] <= keep_go;
		end else if (done_evt || (state_reg == ST_HOLD) || !control_0_reg[`CTL0_ON_BIT]) begin
			control_0_reg[`CTL0_GO_BIT] <= 1'b0;
		end
	end

	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			control_1_reg <= `BYTE_ZERO;
		end else if (wr_ctl1) begin
			control_1_reg <= wb_dat_i & `CTL1_MASK;
		end
	end

	// Pins leave reset as analog, so no input buffer sees a mid-rail level
	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			analog_pin_select_reg <= `PIN_SELECT_RESET;
		end else if (wr_pin) begin
			analog_pin_select_reg <= wb_dat_i;
		end
	end

	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			irq_enable_reg <= `BYTE_ZERO;
		end else if (wr_irq_en) begin
			irq_enable_reg <= wb_dat_i;
		end
	end

	// Write one to clear; a completion in the same cycle wins
	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			done_flag_reg <= 1'b0;
		end else if (done_evt) begin
			done_flag_reg <= 1'b1;
		end else if (wr_flags && wb_dat_i[`IRQ_DONE_BIT]) begin
			done_flag_reg <= 1'b0;
		end
	end

	always_comb begin
		unique case (wb_adr_i)
			`OFF_CONTROL_0:   rd_mux = control_0_reg;
			`OFF_CONTROL_1:   rd_mux = control_1_reg;
			`OFF_RESULT_HIGH: rd_mux = result_byte(result_reg,
				control_0_reg[`CTL0_FORMAT_BIT], 1'b1);
			`OFF_RESULT_LOW:  rd_mux = result_byte(result_reg,
				control_0_reg[`CTL0_FORMAT_BIT], 1'b0);
			`OFF_PIN_SELECT:  rd_mux = analog_pin_select_reg;
			`OFF_IRQ_ENABLE:  rd_mux = irq_enable_reg;
			`OFF_IRQ_FLAGS:   rd_mux = {1'b0, done_flag_reg, 6'h00};
			default:          rd_mux = `BYTE_ZERO;
		endcase
	end

	// One wait-free ack per mapped request; ack falls the cycle after, err repeats while the request is held
	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			ack_reg     <= 1'b0;
			wb_err_o    <= 1'b0;
			rd_data_reg <= `BYTE_ZERO;
		end else begin
			ack_reg     <= bus_req & addr_ok;
			wb_err_o    <= bus_req & ~addr_ok;
			rd_data_reg <= (bus_req && !wb_we_i && addr_ok) ? rd_mux : `BYTE_ZERO;
		end
	end

	assign wb_ack_o = ack_reg;
	assign wb_dat_o = rd_data_reg;
	assign analog_pin_select = analog_pin_select_reg;

	// Only one channel code drives the mux; sampling only while enabled
	always_comb begin
		analog_ctl.channel_valid    = control_0_reg[`CTL0_ON_BIT];
		analog_ctl.channel_select   = control_0_reg[`CTL0_CHAN_HI:`CTL0_CHAN_LO];
		analog_ctl.reference_select = control_0_reg[`CTL0_REF_BIT];
		analog_ctl.sample_hold      = state_reg == ST_CONV;
		analog_ctl.compare_valid    = state_reg == ST_CONV;
		analog_ctl.trial_code       = trial_reg;
	end

	// Level interrupt also serves as wake request from sleep
	assign irq  = done_flag_reg & irq_enable_reg[`IRQ_DONE_BIT];
	assign wake = irq;

endmodule // sar_adc_conversion_control
`default_nettype wire

// ==== sar_adc_checker.sv ====
/*
 Port checker of the converter control.
 Bound to the top module by the bench; sees its ports only.
*/
`timescale 1ns/1ps
`default_nettype none
module sar_adc_checker (
	input wire logic                 mclk,
	input wire logic                 rst_n,
	input wire logic                 wb_cyc_i,
	input wire logic                 wb_stb_i,
	input wire logic                 wb_we_i,
	input wire logic [3:0]           wb_adr_i,
	input wire logic                 wb_sel_i,
	input wire logic [7:0]           wb_dat_i,
	input wire logic [7:0]           wb_dat_o,
	input wire logic                 wb_ack_o,
	input wire logic                 wb_err_o,
	input wire logic                 compare_in,
	input wire sar_pkg::analog_ctl_t analog_ctl,
	input wire logic [7:0]           analog_pin_select,
	input wire logic                 irq,
	input wire logic                 wake
);
	import sar_pkg::*;
	logic req;
	logic wr_irq;
	logic wr_pin;
	assign req = wb_cyc_i && wb_stb_i && !wb_ack_o && !wb_err_o;
	assign wr_irq = wb_cyc_i && wb_stb_i && wb_we_i && wb_adr_i inside {4'h5, 4'h6};
	assign wr_pin = wb_cyc_i && wb_stb_i && wb_we_i && wb_adr_i == 4'h4;
	default clocking cb @(posedge mclk); endclocking
	default disable iff (!rst_n);
	AST_ACK_NEXT: assert property (req && wb_adr_i < 4'h7 |=> wb_ack_o && !wb_err_o)
		else $error("mapped request not answered by ack");
	AST_ERR_NEXT: assert property (req && wb_adr_i > 4'h6 |=> wb_err_o && !wb_ack_o)
		else $error("unmapped request not answered by err");
	AST_ACK_DROP: assert property (wb_ack_o |=> !wb_ack_o)
		else $error("ack longer than one cycle");
	AST_DAT_IDLE: assert property (!wb_ack_o |-> wb_dat_o == 8'h00)
		else $error("read data outside ack");
	AST_WAKE: assert property (wake == irq)
		else $error("wake differs from irq");
	// Flag or mask write is the only way down
	AST_STICKY: assert property ($fell(irq) |-> $past(wr_irq) || $past(wr_irq, 2))
		else $error("irq dropped without software");
	AST_MSB: assert property ($rose(analog_ctl.compare_valid) |-> ##[0:1] analog_ctl.trial_code == 10'h200)
		else $error("first trial not bit 9");
	AST_SPAN: assert property ($rose(analog_ctl.compare_valid) |-> analog_ctl.compare_valid[*8])
		else $error("conversion phase too short");
	AST_PIN: assert property (!$stable(analog_pin_select) |-> $past(wr_pin) || $past(wr_pin, 2))
		else $error("pin select changed unasked");
	cover property ($rose(irq));
	cover property ($fell(analog_ctl.compare_valid));
	cover property (wb_err_o);
endmodule // sar_adc_checker
`default_nettype wire

// ==== sar_front_end_model.sv ====
/*
 Behavioural analog front end: one level per channel, ideal comparator.
 Assumes the trial code and channel come from the converter control.
*/
`timescale 1ns/1ps
`default_nettype none
module sar_front_end_model (
	input wire sar_pkg::analog_ctl_t analog_ctl,
	output logic                     compare_in
);
	import sar_pkg::*;
	logic [9:0] lvl;
	logic [9:0] ref_lvl;
	// Distinct level per channel, so misrouting shows in the code
	assign lvl = 10'h3FF - {analog_ctl.channel_select, 7'h00} - {7'h00, analog_ctl.channel_select};
	// External reference twice the supply; negative side is ground
	assign ref_lvl = analog_ctl.reference_select ? lvl >> 1 : lvl;
	// Outside conversion the line shows the inverse of trial code bit 0, not a comparison
	assign compare_in = analog_ctl.compare_valid ? analog_ctl.trial_code <= ref_lvl
		: ~analog_ctl.trial_code[0];
endmodule // sar_front_end_model
`default_nettype wire

// ==== test_sar_adc_conversion_control.sv ====
/*
 Self-checking bench of the converter control with a front end model.
 Assumes the 20 MHz clock and the hand-over register map.
*/
`timescale 1ns/1ps
`default_nettype none
module test_sar_adc_conversion_control;
	import sar_pkg::*;
	logic        mclk, rst_n, wb_cyc_i, wb_stb_i, wb_we_i, wb_sel_i;
	logic [3:0]  wb_adr_i;
	logic [7:0]  wb_dat_i, wb_dat_o, analog_pin_select;
	logic        wb_ack_o, wb_err_o, compare_in, irq, wake, saw_err;
	analog_ctl_t analog_ctl;
	int          err_total, n_checks;
	// Fast dividers and oscillator are checked for timing and result alike; the model is ideal
	logic [2:0]  cks [8] = '{3'h0, 3'h4, 3'h1, 3'h5, 3'h2, 3'h6, 3'h3, 3'h7};
	int          dv [8] = '{2, 4, 8, 16, 32, 64, 81, 81};
	sar_adc_conversion_control sar_adc_conversion_control_inst (.mclk, .rst_n, .wb_cyc_i,
		.wb_stb_i, .wb_we_i, .wb_adr_i, .wb_sel_i, .wb_dat_i, .wb_dat_o, .wb_ack_o, .wb_err_o,
		.compare_in, .analog_ctl, .analog_pin_select, .irq, .wake);
	sar_front_end_model sar_front_end_model_inst (.analog_ctl, .compare_in);
	initial begin
		mclk = 1'b0;
		forever #25 mclk = ~mclk;
	end
	task automatic end_of_test();
		$display("checks %0d mismatches %0d", n_checks, err_total);
		if (err_total == 0 && n_checks > 0) $display("NO MISMATCHES");
		else $display("MISMATCHES SEEN");
		$finish;
	endtask
	task automatic chk(input logic [7:0] got, input logic [7:0] exp);
		n_checks++;
		if (got !== exp) begin
			err_total++;
			$display("[ERR] %0t got %h want %h", $time, got, exp);
		end
	endtask
	task automatic xfer(input logic w, input logic [3:0] a, input logic [7:0] d,
		output logic [7:0] q);
		int n;
		n = 0;
		@(posedge mclk);
		wb_cyc_i <= 1'b1;
		wb_stb_i <= 1'b1;
		wb_we_i <= w;
		wb_adr_i <= a;
		wb_dat_i <= d;
		do begin
			@(posedge mclk);
			n++;
		end while (wb_ack_o !== 1'b1 && wb_err_o !== 1'b1 && n < 9);
		saw_err = wb_err_o;
		q = wb_dat_o;
		wb_cyc_i <= 1'b0;
		wb_stb_i <= 1'b0;
		if (n == 9) chk(8'h00, 8'h01);
	endtask
	task automatic wr(input logic [3:0] a, input logic [7:0] d);
		logic [7:0] q;
		xfer(1'b1, a, d, q);
	endtask
	task automatic rd(input logic [3:0] a, input logic [7:0] m, input logic [7:0] e);
		logic [7:0] q;
		xfer(1'b0, a, 8'h00, q);
		chk(q & m, e);
	endtask
	function automatic logic [9:0] code(input logic [2:0] ch, input logic rf);
		code = 10'h3FF - {ch, 7'h00} - {7'h00, ch};
		if (rf) code = code >> 1;
	endfunction
	task automatic run(input logic [2:0] ck, ch, input logic rf, fm, input int d);
		logic [7:0] c0, q;
		logic [9:0] e;
		int n;
		realtime t0;
		e = code(ch, rf);
		c0 = {fm, rf, 1'b0, ch, 2'b01};
		wr(4'h4, 8'h01 << ch);
		chk(analog_pin_select, 8'h01 << ch);
		wr(4'h1, {1'b0, ck, 4'h0});
		wr(4'h0, c0);
		chk({3'h0, analog_ctl.channel_valid, analog_ctl.channel_select,
			analog_ctl.reference_select}, {3'h0, 1'b1, ch, rf});
		repeat (20) @(posedge mclk);
		wr(4'h0, c0 | 8'h02);
		t0 = $realtime;
		n = 0;
		do begin
			xfer(1'b0, 4'h0, 8'h00, q);
			n++;
		end while (q[1] !== 1'b0 && n < 400);
		n = int'(($realtime - t0) / 50.0);
		// Eleven periods, then the poll that sees go low lands one to three cycles later
		chk({7'h00, n >= 11 * d && n <= 11 * d + 4}, 8'h01);
		chk(q, c0);
		rd(4'h6, 8'h40, 8'h40);
		rd(4'h2, 8'hFF, fm ? {6'h00, e[9:8]} : e[9:2]);
		rd(4'h3, 8'hFF, fm ? e[7:0] : {e[1:0], 6'h00});
	endtask
	task automatic reset_check();
		rd(4'h4, 8'hFF, 8'hFF);
		rd(4'h5, 8'hFF, 8'h00);
		rd(4'h6, 8'hFF, 8'h00);
		rd(4'h0, 8'hFF, 8'h00);
		rd(4'h7, 8'hFF, 8'h00);
		chk({7'h00, saw_err}, 8'h01);
	endtask
	task automatic irq_check();
		wr(4'h5, 8'h40);
		run(3'h2, 3'h5, 1'b0, 1'b1, 32);
		@(negedge mclk);
		chk({6'h00, irq, wake}, 8'h03);
		repeat (50) @(posedge mclk);
		rd(4'h6, 8'h40, 8'h40);
		wr(4'h5, 8'h00);
		@(negedge mclk);
		chk({6'h00, irq, wake}, 8'h00);
		wr(4'h6, 8'h40);
		wr(4'h5, 8'h40);
		@(negedge mclk);
		chk({6'h00, irq, wake}, 8'h00);
	endtask
	task automatic abort_check();
		logic [9:0] e;
		e = code(3'h5, 1'b0);
		wr(4'h1, 8'h60);
		wr(4'h0, 8'h81);
		wr(4'h0, 8'h83);
		// Abort well inside the trial phase, past the sampling period
		repeat (200) @(posedge mclk);
		wr(4'h0, 8'h81);
		repeat (140) @(posedge mclk);
		rd(4'h6, 8'h40, 8'h00);
		rd(4'h2, 8'hFF, {6'h00, e[9:8]});
		rd(4'h3, 8'hFF, e[7:0]);
		run(3'h2, 3'h6, 1'b1, 1'b0, 32);
	endtask
	initial begin
		{wb_cyc_i, wb_stb_i, wb_we_i, wb_adr_i, wb_dat_i} = 15'h0000;
		wb_sel_i = 1'b1;
		rst_n = 1'b0;
		err_total = 0;
		n_checks = 0;
		repeat (8) @(posedge mclk);
		rst_n <= 1'b1;
		reset_check();
		for (int i = 0; i < 8; i++) begin
			run(cks[i], i[2:0], i[0], i[1], dv[i]);
			wr(4'h6, 8'h40);
		end
		irq_check();
		abort_check();
		wb_sel_i <= 1'b0;
		wr(4'h4, 8'h00);
		wb_sel_i <= 1'b1;
		rd(4'h4, 8'hFF, 8'h40);
		wr(4'h0, 8'h81);
		wr(4'h0, 8'h83);
		repeat (40) @(posedge mclk);
		rst_n <= 1'b0;
		repeat (8) @(posedge mclk);
		rst_n <= 1'b1;
		reset_check();
		end_of_test();
	end
	// Whole run is some 5000 cycles; stop far beyond
	initial begin
		#1000000;
		err_total++;
		end_of_test();
	end
endmodule // test_sar_adc_conversion_control
bind sar_adc_conversion_control sar_adc_checker sar_adc_checker_inst (.mclk, .rst_n,
	.wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i, .wb_sel_i, .wb_dat_i, .wb_dat_o, .wb_ack_o,
	.wb_err_o, .compare_in, .analog_ctl, .analog_pin_select, .irq, .wake);
`default_nettype wire
